// ---- core/dwd_pkg.sv ----
/*
 * Package for the digital watchdog downcounter: register offset, field
 * positions, reset value and timing counts.
 * Assumes an 8-bit data-space register port and a 125 MHz core clock.
 */
package dwd_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DWD_ADDR_CTRL  = 8'hD8;
  localparam logic [7:0] DWD_CTRL_RESET = 8'hFE;
  localparam int         DWD_BIT_ACT    = 0;
  localparam int         DWD_BIT_SWRST  = 1;
  localparam int         DWD_BIT_CNTMSB = 2;
  localparam int         DWD_BIT_CNTLSB = 7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         DWD_STEP_CLKS  = 3072;
  localparam int         DWD_CNT_W      = 7;
  localparam int         DWD_PRE_W      = 12;
  localparam int         DWD_MIN_CLKS   = 3072;
  localparam int         DWD_MAX_CLKS   = 196608;

  typedef struct packed {
    logic                 write;
    logic [7:0]           addr;
    logic [7:0]           data;
  } dwd_req_t;

  typedef struct packed {
    logic [DWD_CNT_W-1:0] cnt;
    logic                 act;
    logic                 rst_req;
  } dwd_core_t;

endpackage

// ---- core/dwd_prescale.sv ----
/*
 * Step prescaler: one pulse every STEP_CLKS clocks while running.
 * Assumes the freeze input comes from logic on the same clock.
 */
`timescale 1ns/1ns
module dwd_prescale
  import dwd_pkg::*;
#(
  parameter int STEP_CLKS = DWD_STEP_CLKS
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_restart,
  input  wire logic i_freeze,
  output logic      o_step
);

  typedef struct packed {
    logic [DWD_PRE_W-1:0] pre;
    logic                 step;
  } dwd_pre_state_t;

  localparam logic [DWD_PRE_W-1:0] PRE_TOP = DWD_PRE_W'(STEP_CLKS - 1);

  dwd_pre_state_t st_r;
  dwd_pre_state_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.step = 1'b0;
    if (i_restart) begin
      st_nxt.pre = '0;
    end else if (!i_freeze) begin
      if (st_r.pre == PRE_TOP) begin
        st_nxt.pre  = '0;
        st_nxt.step = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_step = st_r.step;

  property p_step_period;
    @(posedge i_clk) disable iff (i_rst)
      (st_r.pre == '0 && !i_restart && !i_freeze) |-> ##1 !o_step;
  endproperty
  a_step_period: assert property (p_step_period)
    else $error("step pulse came too soon after wrap");

endmodule

// ---- core/dwd_top.sv ----
/*
 * Digital watchdog downcounter with its control register.
 * Assumes a synchronous data-space write/read port on i_clk, that
 * o_sys_rst drives the chip reset back into i_rst, and that the core
 * reports stop/wait and the interrupt wake-up as same-clock levels.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - Reset loads register FEh: activate 0, reset bit and counts all 1.
// - Reset bit reaching 0 by write, or by countdown while activated, raises system reset.
// - Register bit 7 is counter LSB, bit 2 the top count bit.
// - Counter bit 6 is the reset bit; six bits below set timeout.
// - Sixty-four periods, 3072 to 196608 clocks, by six count bits.
// - Hardware option holds activate bit at 1, writes ignored.
// - Software option: writing 1 activates; cleared only by reset.
// - While inactive the counter is a plain 7-bit timer.
// - At least 28 instructions run after activation before reset.
// - Hardware without external stop: stop acts as wait, keep counting.
// - External stop, pin high: freeze counter until interrupt wake.
module dwd_top
  import dwd_pkg::*;
#(
  parameter int STEP_CLKS = DWD_STEP_CLKS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_hw_activate,
  input  wire logic       i_ext_stop_ctrl,
  input  wire logic       i_nmi_pin,
  input  wire logic       i_stop_exec,
  input  wire logic       i_wake_irq,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_cpu_halt,
  output logic            o_sys_rst
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dwd_core_t  core;
    logic [2:0] nmi_sync;
    logic       nmi_lvl;
    logic       frozen;
    logic       hw_seen;
  } dwd_state_t;

  dwd_state_t st_r;
  dwd_state_t st_nxt;
  dwd_req_t   req;
  logic       step;
  logic       wr_hit;
  logic       nmi_high;
  logic [7:0] reg_view;

  assign req.write = i_wr_en;
  assign req.addr  = i_addr;
  assign req.data  = i_wdata;
  assign wr_hit    = req.write && (req.addr == DWD_ADDR_CTRL);
  assign nmi_high  = st_r.nmi_lvl;

  // ---------------------------------------------------------------
  // Bit reversal between counter and register
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DWD_CNT_W; g++) begin : g_map
      assign reg_view[DWD_BIT_CNTLSB - g] = st_r.core.cnt[g];
    end
  endgenerate
  assign reg_view[DWD_BIT_ACT] = st_r.core.act;

  // ---------------------------------------------------------------
  // Step timebase
  // ---------------------------------------------------------------
  dwd_prescale #(
    .STEP_CLKS (STEP_CLKS)
  ) u_pre (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_restart (wr_hit),
    .i_freeze  (st_r.frozen),
    .o_step    (step)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt              = st_r;
    st_nxt.nmi_sync     = {st_r.nmi_sync[1:0], i_nmi_pin};
    // Pin level moves only once the last two stages agree
    if (st_r.nmi_sync[1] == st_r.nmi_sync[2]) begin
      st_nxt.nmi_lvl = st_r.nmi_sync[2];
    end
    st_nxt.core.rst_req = 1'b0;
    if (!st_r.hw_seen) begin
      st_nxt.hw_seen = 1'b1;
      if (i_hw_activate) begin
        st_nxt.core.act = 1'b1;
      end
    end
    if (st_r.frozen) begin
      if (i_wake_irq) begin
        st_nxt.frozen = 1'b0;
      end
    end else if (i_stop_exec && st_r.core.act && i_hw_activate
                 && i_ext_stop_ctrl && nmi_high) begin
      st_nxt.frozen = 1'b1;
    end
    if (wr_hit) begin
      for (int i = 0; i < DWD_CNT_W; i++) begin
        st_nxt.core.cnt[i] = req.data[DWD_BIT_CNTLSB - i];
      end
      if (req.data[DWD_BIT_ACT] || i_hw_activate) begin
        st_nxt.core.act = 1'b1;
      end
    end else if (step && !st_r.frozen) begin
      st_nxt.core.cnt = st_r.core.cnt - 1'b1;
    end
    if (!st_nxt.core.cnt[DWD_CNT_W-1] && st_r.core.cnt[DWD_CNT_W-1]
        && (st_nxt.core.act || wr_hit)) begin
      st_nxt.core.rst_req = 1'b1;
    end
    if (wr_hit && !req.data[DWD_BIT_SWRST]) begin
      st_nxt.core.rst_req = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r.core.cnt     <= DWD_CTRL_RESET[DWD_BIT_CNTLSB:1];
      st_r.core.act     <= DWD_CTRL_RESET[DWD_BIT_ACT];
      st_r.core.rst_req <= 1'b0;
      st_r.nmi_sync     <= '0;
      st_r.nmi_lvl      <= 1'b0;
      st_r.frozen       <= 1'b0;
      st_r.hw_seen      <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata    = (req.addr == DWD_ADDR_CTRL) ? reg_view : 8'h00;
  assign o_cpu_halt = st_r.frozen;
  assign o_sys_rst  = st_r.core.rst_req;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_write_clear;
    wr_hit && !req.data[DWD_BIT_SWRST];
  endsequence

  property p_write_reset;
    @(posedge i_clk) disable iff (i_rst)
      s_write_clear |=> o_sys_rst;
  endproperty
  a_write_reset: assert property (p_write_reset)
    else $error("write of reset bit 0 gave no reset");

  property p_act_sticky;
    @(posedge i_clk) disable iff (i_rst)
      st_r.core.act |=> st_r.core.act;
  endproperty
  a_act_sticky: assert property (p_act_sticky)
    else $error("activate bit cleared without reset");

  property p_hw_act;
    @(posedge i_clk) disable iff (i_rst)
      (st_r.hw_seen && i_hw_activate) |-> st_r.core.act;
  endproperty
  a_hw_act: assert property (p_hw_act)
    else $error("hardware option left watchdog inactive");

  property p_reverse;
    @(posedge i_clk) disable iff (i_rst)
      wr_hit |=> (st_r.core.cnt[0] == $past(i_wdata[7]))
                 && (st_r.core.cnt[5] == $past(i_wdata[2]));
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("register write not reversed into counter");

  property p_frozen_hold;
    @(posedge i_clk) disable iff (i_rst)
      (st_r.frozen && !wr_hit) |=> $stable(st_r.core.cnt);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold)
    else $error("counter moved while frozen");

  property p_step_dec;
    @(posedge i_clk) disable iff (i_rst)
      (step && !st_r.frozen && !wr_hit)
        |=> st_r.core.cnt == $past(st_r.core.cnt) - 7'h01;
  endproperty
  a_step_dec: assert property (p_step_dec)
    else $error("counter did not step down");

  property p_quiet_no_step;
    @(posedge i_clk) disable iff (i_rst)
      (!step && !wr_hit) |=> $stable(st_r.core.cnt);
  endproperty
  a_quiet_no_step: assert property (p_quiet_no_step)
    else $error("counter changed without a step");

  property p_no_spurious;
    @(posedge i_clk) disable iff (i_rst)
      (!wr_hit && !st_r.core.act) |=> !o_sys_rst;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("reset raised by inactive timer");

  property p_no_early;
    @(posedge i_clk) disable iff (i_rst)
      (wr_hit && i_wdata[DWD_BIT_SWRST] && !i_wdata[DWD_BIT_CNTLSB])
        |=> !o_sys_rst [*8];
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("reset too soon after reload");

endmodule

// ---- tb/dwd_top_test.sv ----
/*
 * Self-checking bench for dwd_top: register writes, countdown,
 * activation options and stop freeze.
 * Assumes a shortened step count and a bench-driven reset.
 */
`timescale 1ns/1ns
module dwd_top_test;
  import dwd_pkg::*;
  localparam int STEP = 16;
  logic       i_clk           = 1'b0;
  logic       i_rst           = 1'b1;
  logic       i_hw_activate   = 1'b0;
  logic       i_ext_stop_ctrl = 1'b0;
  logic       i_nmi_pin       = 1'b0;
  logic       i_stop_exec     = 1'b0;
  logic       i_wake_irq      = 1'b0;
  logic       i_wr_en         = 1'b0;
  logic [7:0] i_addr          = DWD_ADDR_CTRL;
  logic [7:0] i_wdata         = 8'h00;
  logic [7:0] o_rdata;
  logic [7:0] v;
  logic       o_cpu_halt;
  logic       o_sys_rst;
  int         bad_count       = 0;
  int         checked         = 0;
  int         n;
  int         m;

  always #4 i_clk = ~i_clk;

  dwd_top #(.STEP_CLKS(STEP)) u_dwd_top (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_hw_activate   (i_hw_activate),
    .i_ext_stop_ctrl (i_ext_stop_ctrl),
    .i_nmi_pin       (i_nmi_pin),
    .i_stop_exec     (i_stop_exec),
    .i_wake_irq      (i_wake_irq),
    .i_wr_en         (i_wr_en),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .o_rdata         (o_rdata),
    .o_cpu_halt      (o_cpu_halt),
    .o_sys_rst       (o_sys_rst)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic hw, input logic ext, input logic nmi);
    @(posedge i_clk);
    i_rst           <= 1'b1;
    i_hw_activate   <= hw;
    i_ext_stop_ctrl <= ext;
    i_nmi_pin       <= nmi;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    i_addr  <= DWD_ADDR_CTRL;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
    i_addr <= DWD_ADDR_CTRL;
    #1;
  endtask

  task automatic pulse_stop(input logic wake);
    @(posedge i_clk);
    i_stop_exec <= ~wake;
    i_wake_irq  <= wake;
    @(posedge i_clk);
    i_stop_exec <= 1'b0;
    i_wake_irq  <= 1'b0;
    #1;
  endtask

  task automatic wait_rd(input logic [7:0] old, output int cnt);
    cnt = 0;
    while (o_rdata === old) begin
      @(posedge i_clk);
      #1;
      cnt++;
      if (cnt > 4 * STEP) begin
        bad_count++;
        test_done();
      end
    end
  endtask

  task automatic wait_rst(output int cnt);
    cnt = 0;
    while (o_sys_rst !== 1'b1) begin
      @(posedge i_clk);
      #1;
      cnt++;
      if (cnt > 4 * STEP) begin
        bad_count++;
        test_done();
      end
    end
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    check(o_rdata, DWD_CTRL_RESET);
    // Timer mode with reversed view
    wr(DWD_ADDR_CTRL, 8'h82);
    check(o_rdata, 8'h82);
    wait_rd(8'h82, n);
    check(o_rdata, 8'h02);
    wait_rd(8'h02, m);
    check(o_rdata, 8'hFC);
    check(8'(m), 8'(STEP));
    check(o_sys_rst, 1'b0);
    wr(8'hD9, 8'h00);
    check(o_rdata, 8'hFC);
    rd(8'hD9, v);
    check(v, 8'h00);
    // Software activation locks
    wr(DWD_ADDR_CTRL, 8'h83);
    wr(DWD_ADDR_CTRL, 8'h82);
    check(o_rdata, 8'h83);
    wait_rst(n);
    check(n >= 2 * STEP - 2 && n <= 2 * STEP + 2, 1'b1);
    do_reset(1'b0, 1'b0, 1'b0);
    check(o_rdata, DWD_CTRL_RESET);
    wr(DWD_ADDR_CTRL, 8'hFD);
    check(o_sys_rst, 1'b1);
    // Hardware option, stop acts as wait
    do_reset(1'b1, 1'b0, 1'b0);
    check(o_rdata, 8'hFF);
    wr(DWD_ADDR_CTRL, 8'h82);
    check(o_rdata, 8'h83);
    pulse_stop(1'b0);
    check(o_cpu_halt, 1'b0);
    wait_rd(8'h83, n);
    check(o_rdata, 8'h03);
    // External stop with pin high freezes
    do_reset(1'b1, 1'b1, 1'b1);
    wr(DWD_ADDR_CTRL, 8'h83);
    pulse_stop(1'b0);
    check(o_cpu_halt, 1'b1);
    repeat (3 * STEP) @(posedge i_clk);
    #1;
    check(o_rdata, 8'h83);
    check(o_sys_rst, 1'b0);
    pulse_stop(1'b1);
    check(o_cpu_halt, 1'b0);
    wait_rd(8'h83, n);
    check(o_rdata, 8'h03);
    // Pin low: stop acts as wait
    do_reset(1'b1, 1'b1, 1'b0);
    wr(DWD_ADDR_CTRL, 8'h83);
    pulse_stop(1'b0);
    check(o_cpu_halt, 1'b0);
    test_done();
  end
endmodule
